// ===== bobd_pkg.sv
package bobd_pkg;

    // ------------------------------------------------------------
    // operation selection
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        BOBD_OP_NONE,
        BOBD_OP_FILE_BIT_CLEAR,
        BOBD_OP_FILE_BIT_SET,
        BOBD_OP_SKIP_IF_BIT_CLEAR,
        BOBD_OP_SKIP_IF_BIT_SET,
        BOBD_OP_LITERAL_REL_BRANCH,
        BOBD_OP_WORKING_REG_REL_BRANCH
    } bobd_op_t;

    // ------------------------------------------------------------
    // widths and ranges
    // ------------------------------------------------------------
    localparam int unsigned FILE_ADDR_W   = 7;
    localparam int unsigned BIT_IDX_W     = 3;
    localparam int unsigned DATA_W        = 8;
    localparam int unsigned PC_W          = 15;
    localparam int unsigned BRANCH_LIT_W  = 9;
    localparam logic [6:0]  FILE_ADDR_MAX = 7'h7f;
    localparam logic [2:0]  BIT_IDX_MAX   = 3'h7;

    // status register address inside the bank
    localparam logic [6:0]  STATUS_ADDR   = 7'h03;
    localparam logic [7:0]  STATUS_RESET  = 8'h18;
    localparam logic [14:0] PC_RESET      = 15'h0000;
    localparam logic [14:0] PC_STEP       = 15'h0001;

endpackage : bobd_pkg

// ===== bobd_bit_alu.sv
`timescale 1ns/1ps
module bobd_bit_alu (
    input  wire logic [7:0] data_in,
    input  wire logic [2:0] bit_idx,
    input  wire logic       set_not_clear,
    output logic      [7:0] data_out,
    output logic            bit_value
);

    // ------------------------------------------------------------
    // single-bit modify and test
    // ------------------------------------------------------------
    logic [7:0] mask;

    always_comb begin
        mask      = 8'h01 << bit_idx;
        data_out  = set_not_clear ? (data_in | mask) : (data_in & ~mask);
        bit_value = |(data_in & mask);
    end

endmodule // bobd_bit_alu

// ===== bobd_core.sv
`timescale 1ns/1ps
// Functional notes
// - Bit clear writes zero into bit b of file f (f 0..127, b 0..7), others unchanged.
// - Bit set writes one into bit b of file f with the same ranges, others unchanged.
// - Skip-if-clear continues on a set bit and squashes the next instruction on a clear bit.
// - Skip-if-set continues on a clear bit and squashes the next instruction on a set bit.
// - Literal branch sign-extends its 9-bit literal and loads pc plus one plus it.
// - Literal branch offsets span -256..255 and always take two cycles.
// - Working-register branch adds unsigned w to pc plus one and takes two cycles.
module bobd_core (
    input  wire logic                 clock,
    input  wire logic                 reset,
    input  wire logic                 instr_valid,
    input  wire bobd_pkg::bobd_op_t   instr_op,
    input  wire logic [6:0]           file_addr,
    input  wire logic [2:0]           bit_idx,
    input  wire logic [8:0]           branch_lit,
    input  wire logic [7:0]           working_reg,
    input  wire logic [7:0]           file_rdata,
    output logic                      file_we,
    output logic      [6:0]           file_waddr,
    output logic      [7:0]           file_wdata,
    output logic      [14:0]          pc,
    output logic                      squash_next,
    output logic                      busy,
    output logic      [7:0]           status
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        BOBD_EXEC,
        BOBD_SECOND
    } bobd_state_t;

    bobd_state_t  state_r,  state_nxt;
    logic [14:0]  pc_r,     pc_nxt;
    logic         we_r,     we_nxt;
    logic [6:0]   waddr_r,  waddr_nxt;
    logic [7:0]   wdata_r,  wdata_nxt;
    logic [7:0]   status_r, status_nxt;

    logic [7:0]   alu_out;
    logic         alu_bit;
    logic         start;
    logic [14:0]  pc_inc;

    bobd_bit_alu u_alu (
        .data_in       (file_rdata),
        .bit_idx       (bit_idx),
        .set_not_clear (instr_op == bobd_pkg::BOBD_OP_FILE_BIT_SET),
        .data_out      (alu_out),
        .bit_value     (alu_bit)
    );

    // sign-extends the 9-bit literal to pc width
    function automatic logic [14:0] sext_lit(input logic [8:0] k);
        sext_lit = {{(bobd_pkg::PC_W - bobd_pkg::BRANCH_LIT_W){k[8]}}, k};
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        start      = instr_valid && (state_r == BOBD_EXEC);
        pc_inc     = pc_r + bobd_pkg::PC_STEP;
        state_nxt  = state_r;
        pc_nxt     = pc_r;
        we_nxt     = 1'b0;
        waddr_nxt  = waddr_r;
        wdata_nxt  = wdata_r;
        status_nxt = status_r;
        case (state_r)
            BOBD_EXEC: begin
                if (start) begin
                    pc_nxt = pc_inc;
                    case (instr_op)
                        bobd_pkg::BOBD_OP_FILE_BIT_CLEAR,
                        bobd_pkg::BOBD_OP_FILE_BIT_SET: begin
                            we_nxt    = 1'b1;
                            waddr_nxt = file_addr;
                            wdata_nxt = alu_out;
                            if (file_addr == bobd_pkg::STATUS_ADDR) begin
                                status_nxt = alu_out;
                            end
                        end
                        bobd_pkg::BOBD_OP_SKIP_IF_BIT_CLEAR: begin
                            if (!alu_bit) begin
                                state_nxt = BOBD_SECOND;
                                pc_nxt    = pc_inc + bobd_pkg::PC_STEP;
                            end
                        end
                        bobd_pkg::BOBD_OP_SKIP_IF_BIT_SET: begin
                            if (alu_bit) begin
                                state_nxt = BOBD_SECOND;
                                pc_nxt    = pc_inc + bobd_pkg::PC_STEP;
                            end
                        end
                        bobd_pkg::BOBD_OP_LITERAL_REL_BRANCH: begin
                            pc_nxt    = pc_inc + sext_lit(branch_lit);
                            state_nxt = BOBD_SECOND;
                        end
                        bobd_pkg::BOBD_OP_WORKING_REG_REL_BRANCH: begin
                            pc_nxt    = pc_inc + {7'h00, working_reg};
                            state_nxt = BOBD_SECOND;
                        end
                        default: begin
                            pc_nxt = pc_inc;
                        end
                    endcase
                end
            end
            BOBD_SECOND: begin
                state_nxt = BOBD_EXEC;
            end
            default: begin
                state_nxt = BOBD_EXEC;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (reset) begin
            state_r  <= BOBD_EXEC;
            pc_r     <= bobd_pkg::PC_RESET;
            we_r     <= 1'b0;
            waddr_r  <= '0;
            wdata_r  <= '0;
            status_r <= bobd_pkg::STATUS_RESET;
        end else begin
            state_r  <= state_nxt;
            pc_r     <= pc_nxt;
            we_r     <= we_nxt;
            waddr_r  <= waddr_nxt;
            wdata_r  <= wdata_nxt;
            status_r <= status_nxt;
        end
    end

    assign file_we     = we_r;
    assign file_waddr  = waddr_r;
    assign file_wdata  = wdata_r;
    assign pc          = pc_r;
    assign status      = status_r;
    assign busy        = (state_r == BOBD_SECOND);
    assign squash_next = busy;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    bit_clear_write_a: assert property (@(posedge clock) disable iff (reset)
        start && instr_op == bobd_pkg::BOBD_OP_FILE_BIT_CLEAR
        |=> file_we && file_wdata == ($past(file_rdata) & ~(8'h01 << $past(bit_idx))))
        else $error("bit clear wrote wrong data");

    bit_set_write_a: assert property (@(posedge clock) disable iff (reset)
        start && instr_op == bobd_pkg::BOBD_OP_FILE_BIT_SET
        |=> file_we && file_wdata == ($past(file_rdata) | (8'h01 << $past(bit_idx))))
        else $error("bit set wrote wrong data");

    skip_clear_a: assert property (@(posedge clock) disable iff (reset)
        start && instr_op == bobd_pkg::BOBD_OP_SKIP_IF_BIT_CLEAR && !file_rdata[bit_idx]
        |=> squash_next && pc == $past(pc) + 15'h0002 ##1 !squash_next)
        else $error("skip if clear wrong");

    skip_clear_pass_a: assert property (@(posedge clock) disable iff (reset)
        start && instr_op == bobd_pkg::BOBD_OP_SKIP_IF_BIT_CLEAR && file_rdata[bit_idx]
        |=> !squash_next && pc == $past(pc) + 15'h0001)
        else $error("skip if clear skipped on set bit");

    skip_set_a: assert property (@(posedge clock) disable iff (reset)
        start && instr_op == bobd_pkg::BOBD_OP_SKIP_IF_BIT_SET && file_rdata[bit_idx]
        |=> squash_next && pc == $past(pc) + 15'h0002 ##1 !squash_next)
        else $error("skip if set wrong");

    skip_set_pass_a: assert property (@(posedge clock) disable iff (reset)
        start && instr_op == bobd_pkg::BOBD_OP_SKIP_IF_BIT_SET && !file_rdata[bit_idx]
        |=> !squash_next && pc == $past(pc) + 15'h0001)
        else $error("skip if set skipped on clear bit");

    lit_target_a: assert property (@(posedge clock) disable iff (reset)
        start && instr_op == bobd_pkg::BOBD_OP_LITERAL_REL_BRANCH
        |=> pc == $past(pc) + 15'h0001 + {{6{$past(branch_lit[8])}}, $past(branch_lit)})
        else $error("literal branch target wrong");

    lit_two_cycle_a: assert property (@(posedge clock) disable iff (reset)
        start && instr_op == bobd_pkg::BOBD_OP_LITERAL_REL_BRANCH
        |=> busy ##1 !busy)
        else $error("literal branch not two cycles");

    wreg_branch_a: assert property (@(posedge clock) disable iff (reset)
        start && instr_op == bobd_pkg::BOBD_OP_WORKING_REG_REL_BRANCH
        |=> pc == $past(pc) + 15'h0001 + {7'h00, $past(working_reg)} && busy ##1 !busy)
        else $error("working register branch wrong");

    status_kept_a: assert property (@(posedge clock) disable iff (reset)
        !(start && file_addr == bobd_pkg::STATUS_ADDR
          && (instr_op == bobd_pkg::BOBD_OP_FILE_BIT_CLEAR
              || instr_op == bobd_pkg::BOBD_OP_FILE_BIT_SET))
        |=> $stable(status))
        else $error("status changed unexpectedly");

endmodule // bobd_core

// ===== tb_bit_ops_branch_decoder.sv
`timescale 1ns/1ps
module tb_bit_ops_branch_decoder;
    logic               clock;
    logic               reset;
    logic               instr_valid;
    bobd_pkg::bobd_op_t instr_op;
    logic [6:0]         file_addr;
    logic [2:0]         bit_idx;
    logic [8:0]         branch_lit;
    logic [7:0]         working_reg;
    logic [7:0]         file_rdata;
    logic               file_we;
    logic [6:0]         file_waddr;
    logic [7:0]         file_wdata;
    logic [14:0]        pc;
    logic               squash_next;
    logic               busy;
    logic [7:0]         status;
    logic [14:0]        exp_pc;
    logic [7:0]         exp_st;
    int                 failures = 0;
    int                 total_checks = 0;
    int                 cycles = 0;

    bobd_core DUT (.clock(clock), .reset(reset), .instr_valid(instr_valid),
        .instr_op(instr_op), .file_addr(file_addr), .bit_idx(bit_idx),
        .branch_lit(branch_lit), .working_reg(working_reg), .file_rdata(file_rdata),
        .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata), .pc(pc),
        .squash_next(squash_next), .busy(busy), .status(status));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            conclude();
        end
    end

    // ------------------------------------------------------------
    // checks and drivers
    // ------------------------------------------------------------
    task automatic chk_pc(input string n, input logic [14:0] e, input logic [14:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_v(input string n, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s: expected %h seen %h", n, e, g);
        end
    endtask

    // one request; a two-cycle one gets a refused request in its busy cycle
    task automatic run(input bobd_pkg::bobd_op_t op, input logic [6:0] a, input logic [2:0] b,
                       input logic [8:0] k, input logic [7:0] w, input logic [7:0] rd,
                       input logic two, input logic [7:0] wd);
        logic wr;
        wr = (op == bobd_pkg::BOBD_OP_FILE_BIT_CLEAR) || (op == bobd_pkg::BOBD_OP_FILE_BIT_SET);
        instr_valid = 1'b1;
        instr_op = op;
        file_addr = a;
        bit_idx = b;
        branch_lit = k;
        working_reg = w;
        file_rdata = rd;
        @(posedge clock); #1;
        chk_pc("pc", exp_pc, pc);
        chk_v("busy", {7'h00, two}, {7'h00, busy});
        chk_v("squash", {7'h00, two}, {7'h00, squash_next});
        chk_v("write strobe", {7'h00, wr}, {7'h00, file_we});
        if (wr) begin
            chk_v("write data", wd, file_wdata);
            chk_pc("write addr", {8'h00, a}, {8'h00, file_waddr});
        end
        chk_v("status", exp_st, status);
        if (two) begin
            instr_op = bobd_pkg::BOBD_OP_LITERAL_REL_BRANCH;
            branch_lit = 9'h0ff;
            @(posedge clock); #1;
            chk_pc("pc in no-op", exp_pc, pc);
            chk_v("busy end", 8'h00, {7'h00, busy});
        end
    endtask

    task automatic idle();
        instr_valid = 1'b0;
        @(posedge clock); #1;
        chk_pc("pc idle", exp_pc, pc);
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic bit_ops();
        for (int i = 0; i < 8; i++) begin
            exp_pc = exp_pc + 15'h0001;
            run(bobd_pkg::BOBD_OP_FILE_BIT_CLEAR, 7'h7f, i[2:0], 9'h000, 8'h00, 8'hff, 1'b0,
                8'hff & ~(8'h01 << i));
            exp_pc = exp_pc + 15'h0001;
            run(bobd_pkg::BOBD_OP_FILE_BIT_SET, 7'h00, i[2:0], 9'h000, 8'h00, 8'h00, 1'b0,
                8'h01 << i);
        end
        idle();
    endtask

    task automatic skips();
        exp_pc = exp_pc + 15'h0001;
        run(bobd_pkg::BOBD_OP_SKIP_IF_BIT_CLEAR, 7'h10, 3'h5, 9'h0, 8'h0, 8'h20, 1'b0, 8'h0);
        exp_pc = exp_pc + 15'h0002;
        run(bobd_pkg::BOBD_OP_SKIP_IF_BIT_CLEAR, 7'h10, 3'h5, 9'h0, 8'h0, 8'hdf, 1'b1, 8'h0);
        exp_pc = exp_pc + 15'h0001;
        run(bobd_pkg::BOBD_OP_SKIP_IF_BIT_SET, 7'h11, 3'h0, 9'h0, 8'h0, 8'hfe, 1'b0, 8'h0);
        exp_pc = exp_pc + 15'h0002;
        run(bobd_pkg::BOBD_OP_SKIP_IF_BIT_SET, 7'h11, 3'h7, 9'h0, 8'h0, 8'h80, 1'b1, 8'h0);
        idle();
    endtask

    task automatic branches();
        exp_pc = exp_pc + 15'h0001 + 15'h7f00;
        run(bobd_pkg::BOBD_OP_LITERAL_REL_BRANCH, 7'h0, 3'h0, 9'h100, 8'h0, 8'h0, 1'b1, 8'h0);
        exp_pc = exp_pc + 15'h0001 + 15'h00ff;
        run(bobd_pkg::BOBD_OP_LITERAL_REL_BRANCH, 7'h0, 3'h0, 9'h0ff, 8'h0, 8'h0, 1'b1, 8'h0);
        exp_pc = exp_pc + 15'h0001 + 15'h00ff;
        run(bobd_pkg::BOBD_OP_WORKING_REG_REL_BRANCH, 7'h0, 3'h0, 9'h1ff, 8'hff, 8'h0, 1'b1, 8'h0);
        exp_pc = exp_pc + 15'h0001 + 15'h0080;
        run(bobd_pkg::BOBD_OP_WORKING_REG_REL_BRANCH, 7'h0, 3'h0, 9'h100, 8'h80, 8'h0, 1'b1, 8'h0);
        idle();
    endtask

    task automatic status_write();
        exp_pc = exp_pc + 15'h0001;
        exp_st = 8'h10;
        run(bobd_pkg::BOBD_OP_FILE_BIT_CLEAR, bobd_pkg::STATUS_ADDR, 3'h3, 9'h0, 8'h0,
            bobd_pkg::STATUS_RESET, 1'b0, 8'h10);
        exp_pc = exp_pc + 15'h0001;
        exp_st = 8'h11;
        run(bobd_pkg::BOBD_OP_FILE_BIT_SET, bobd_pkg::STATUS_ADDR, 3'h0, 9'h0, 8'h0, 8'h10,
            1'b0, 8'h11);
        exp_pc = exp_pc + 15'h0001;
        run(bobd_pkg::BOBD_OP_NONE, bobd_pkg::STATUS_ADDR, 3'h1, 9'h0, 8'h0, 8'h11, 1'b0, 8'h0);
        idle();
    endtask

    task automatic mid_reset();
        reset = 1'b1;
        instr_valid = 1'b0;
        @(posedge clock); #1;
        reset = 1'b0;
        exp_pc = bobd_pkg::PC_RESET;
        exp_st = bobd_pkg::STATUS_RESET;
        chk_pc("pc after reset", exp_pc, pc);
        chk_v("status after reset", exp_st, status);
        chk_v("busy after reset", 8'h00, {7'h00, busy});
        chk_v("strobe after reset", 8'h00, {7'h00, file_we});
        exp_pc = exp_pc + 15'h0001;
        run(bobd_pkg::BOBD_OP_FILE_BIT_SET, 7'h22, 3'h6, 9'h0, 8'h0, 8'h00, 1'b0, 8'h40);
        idle();
    endtask

    task automatic conclude();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        instr_valid = 1'b0;
        instr_op = bobd_pkg::BOBD_OP_NONE;
        file_addr = 7'h00;
        bit_idx = 3'h0;
        branch_lit = 9'h000;
        working_reg = 8'h00;
        file_rdata = 8'h00;
        exp_pc = bobd_pkg::PC_RESET;
        exp_st = bobd_pkg::STATUS_RESET;
        repeat (10) @(posedge clock);
        #1;
        reset = 1'b0;
        bit_ops();
        skips();
        branches();
        status_write();
        mid_reset();
        conclude();
    end
endmodule // tb_bit_ops_branch_decoder
